/* rtl/tlic_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none

module tlic_arbiter #(
  parameter int N = 14,
  parameter int IW = 4
) (
  // Requests and their levels
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] lvl,
  // Winner
  output logic win_valid,
  output logic win_hi,
  output logic [IW-1:0] win_idx
);

  logic [N-1:0] hi_req;
  logic [N-1:0] pool;

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_split
      assign hi_req[g] = req[g] & lvl[g];
    end
  endgenerate

  // High level first, then lowest index wins
  assign win_hi = |hi_req;
  assign pool = win_hi ? hi_req : req;
  assign win_valid = |req;

  always_comb begin
    win_idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pool[i]) begin
        win_idx = IW'(i);
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/tlic_core.sv */
`timescale 1ns/1ps
`default_nettype none

module tlic_core #(
  parameter logic [13:0] HW_CLEAR_MASK = tlic_pkg::HW_CLEAR_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Source events and software flag access
  input wire logic [13:0] src_event,
  input wire logic [13:0] sw_set_pend,
  input wire logic [13:0] sw_clr_pend,
  // Enable and level register writes
  input wire logic main_en_we,
  input wire logic [7:0] main_en_wdata,
  input wire logic ext_en_we,
  input wire logic [7:0] ext_en_wdata,
  input wire logic main_lvl_we,
  input wire logic [7:0] main_lvl_wdata,
  input wire logic ext_lvl_we,
  input wire logic [7:0] ext_lvl_wdata,
  // Core sequencer
  input wire tlic_pkg::tlic_core_s core,
  output tlic_pkg::tlic_call_s call,
  // Readback
  output logic [13:0] pend_flags,
  output logic [7:0] main_irq_enable_reg,
  output logic [7:0] extended_irq_enable_reg,
  output logic [7:0] main_irq_level_reg,
  output logic [7:0] extended_irq_level_reg,
  output logic active_lo,
  output logic active_hi
);

  localparam int N = tlic_pkg::NUM_SRC;

  tlic_pkg::tlic_state_e state_reg;
  tlic_pkg::tlic_state_e state_next;
  logic [1:0] cnt_reg;
  logic [13:0] pend_reg;
  logic [13:0] pend_next;
  logic [13:0] req_reg;
  logic [13:0] ind_en;
  logic [13:0] lvl_vec;
  logic [13:0] hw_clr;
  logic global_irq_gate;
  logic hold_reg;
  logic act_lo_reg;
  logic act_hi_reg;
  logic win_valid;
  logic win_hi;
  logic [3:0] win_idx;
  logic [3:0] slot;
  logic allowed;
  logic take;
  tlic_pkg::tlic_call_s call_reg;

  assign global_irq_gate = main_irq_enable_reg[tlic_pkg::GATE_BIT];

  // Map each source to its enable and level bit
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_map
      localparam int B = (g < tlic_pkg::MAIN_SRC) ? g :
        ((g == N - 1) ? tlic_pkg::EXT_LAST_BIT : g - tlic_pkg::MAIN_SRC);
      if (g < tlic_pkg::MAIN_SRC) begin : g_main
        assign ind_en[g] = main_irq_enable_reg[B];
        assign lvl_vec[g] = main_irq_level_reg[B];
      end else begin : g_ext
        assign ind_en[g] = extended_irq_enable_reg[B];
        assign lvl_vec[g] = extended_irq_level_reg[B];
      end
    end
  endgenerate

  // Enable registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      main_irq_enable_reg <= tlic_pkg::ENABLE_RST;
      extended_irq_enable_reg <= tlic_pkg::ENABLE_RST;
    end else begin
      if (main_en_we) begin
        main_irq_enable_reg <= main_en_wdata;
      end
      if (ext_en_we) begin
        extended_irq_enable_reg <= ext_en_wdata & tlic_pkg::EXT_WMASK;
      end
    end
  end

  // Level registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      main_irq_level_reg <= tlic_pkg::LEVEL_RST;
      extended_irq_level_reg <= tlic_pkg::LEVEL_RST;
    end else begin
      if (main_lvl_we) begin
        main_irq_level_reg <= main_lvl_wdata & 8'h7f;
      end
      if (ext_lvl_we) begin
        extended_irq_level_reg <= ext_lvl_wdata & tlic_pkg::EXT_WMASK;
      end
    end
  end

  // Pending flags: a set in the same cycle as a clear wins
  assign hw_clr = take ? (HW_CLEAR_MASK & (14'h0001 << win_idx)) : 14'h0000;
  assign pend_next = (pend_reg & ~(sw_clr_pend | hw_clr))
    | src_event | sw_set_pend;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pend_reg <= tlic_pkg::PEND_RST;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // Detection stage, sampled every cycle. Because it lags the enables by a
  // cycle, a request posted as software clears an enable can still be taken
  // by a single-cycle follower, while a multi-cycle one sees it withdrawn.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      req_reg <= 14'h0000;
    end else begin
      req_reg <= pend_reg & ind_en & {N{global_irq_gate}};
    end
  end

  tlic_arbiter #(
    .N(N),
    .IW(4)
  ) u_arb (
    .req(req_reg),
    .lvl(lvl_vec),
    .win_valid(win_valid),
    .win_hi(win_hi),
    .win_idx(win_idx)
  );

  // Nesting: high may enter over low, nothing enters over high
  assign allowed = win_valid && (win_hi ? !act_hi_reg : !(act_lo_reg || act_hi_reg));

  // Only at a boundary that is not a return, so exactly one instruction
  // runs between a return and the next call
  assign take = (state_reg == tlic_pkg::TLIC_RUN) && core.instr_done
    && !core.return_from_service_done && allowed;

  // Marks the first boundary after a return; only the re-entry check reads it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hold_reg <= 1'b0;
    end else if (core.instr_done && state_reg == tlic_pkg::TLIC_RUN) begin
      hold_reg <= core.return_from_service_done;
    end
  end

  // Active service levels
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      act_lo_reg <= 1'b0;
      act_hi_reg <= 1'b0;
    end else if (take) begin
      if (win_hi) begin
        act_hi_reg <= 1'b1;
      end else begin
        act_lo_reg <= 1'b1;
      end
    end else if (core.instr_done && core.return_from_service_done && state_reg == tlic_pkg::TLIC_RUN) begin
      // Return closes the innermost level; flow resumes at the saved address
      if (act_hi_reg) begin
        act_hi_reg <= 1'b0;
      end else begin
        act_lo_reg <= 1'b0;
      end
    end
  end

  // Forced call sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tlic_pkg::TLIC_RUN: begin
        if (take) begin
          state_next = tlic_pkg::TLIC_CALL;
        end
      end
      tlic_pkg::TLIC_CALL: begin
        if (cnt_reg == tlic_pkg::CALL_CNT_LAST) begin
          state_next = tlic_pkg::TLIC_RUN;
        end
      end
      default: state_next = tlic_pkg::TLIC_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= tlic_pkg::TLIC_RUN;
      cnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_reg == tlic_pkg::TLIC_CALL) ? cnt_reg + 2'h1 : 2'h0;
    end
  end

  // The unused slot before the last source is skipped in the vector table
  assign slot = (win_idx == tlic_pkg::SKIP_SLOT_IDX) ? win_idx + 4'h1 : win_idx;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      call_reg <= '0;
    end else begin
      call_reg.req <= take;
      call_reg.busy <= (state_next == tlic_pkg::TLIC_CALL);
      if (take) begin
        call_reg.hi <= win_hi;
        call_reg.vector <= tlic_pkg::VEC_BASE + (16'(slot) << tlic_pkg::VEC_SHIFT);
      end
    end
  end

  assign call = call_reg;
  assign pend_flags = pend_reg;
  assign active_lo = act_lo_reg;
  assign active_hi = act_hi_reg;

  // Checks
  sequence s_call_run;
    call_reg.busy [*4] ##1 !call_reg.busy;
  endsequence

  sequence s_boundary_blocked;
    core.instr_done && core.return_from_service_done && state_reg == tlic_pkg::TLIC_RUN;
  endsequence

  sequence s_after_return;
    core.instr_done && !core.return_from_service_done && hold_reg && state_reg == tlic_pkg::TLIC_RUN
      && allowed;
  endsequence

  a_pend_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |src_event |=> ((pend_reg & $past(src_event)) == $past(src_event)))
    else $error("source event did not set its pending flag");

  a_gate_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take |-> $past(global_irq_gate))
    else $error("call taken while global gate was off");

  a_req_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 ((req_reg & ~$past(ind_en)) == 14'h0000))
    else $error("request raised by a disabled source");

  a_call_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
    call_reg.req |-> s_call_run)
    else $error("forced call did not last four cycles");

  a_return_skip: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_boundary_blocked |=> !call_reg.req)
    else $error("call taken at a return boundary");

  a_reentry_next: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_after_return |=> call_reg.req)
    else $error("pending request not taken after one instruction past return");

  a_hi_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    call_reg.req |-> !$past(act_hi_reg, 1))
    else $error("high level service was preempted");

  a_low_waits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (call_reg.req && !call_reg.hi) |-> !$past(act_lo_reg, 1))
    else $error("low request entered over running low service");

  a_level_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (take && !lvl_vec[win_idx]) |-> ((req_reg & lvl_vec) == 14'h0000))
    else $error("low request chosen over a high one");

  a_rank_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take |-> (req_reg[win_idx] && ((req_reg & ~(lvl_vec ^ {N{lvl_vec[win_idx]}})
      & ((14'h0001 << win_idx) - 14'h0001)) == 14'h0000)))
    else $error("same level request of better rank passed over");

  a_vector_form: assert property (@(posedge sys_clk) disable iff (!rst_n)
    call_reg.req |-> (call_reg.vector[2:0] == 3'h3 && call_reg.vector < 16'h0078))
    else $error("vector outside the table");

  a_level_reset: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> (main_irq_level_reg == 8'h00 && extended_irq_level_reg == 8'h00))
    else $error("level not low after reset");

  a_hw_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (take && HW_CLEAR_MASK[win_idx] && !src_event[win_idx] && !sw_set_pend[win_idx])
    |=> !pend_reg[$past(win_idx)])
    else $error("auto clearing flag stayed set after vectoring");

endmodule

`default_nettype wire

/* rtl/tlic_pkg.sv */
package tlic_pkg;

  // Source count and register field layout
  localparam int NUM_SRC = 14;
  localparam int MAIN_SRC = 7;
  localparam int GATE_BIT = 7;
  localparam int EXT_LAST_BIT = 7;
  localparam logic [7:0] EXT_WMASK = 8'hbf;

  // Values after reset, and the default hardware clear mask
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [13:0] PEND_RST = 14'h0000;
  localparam logic [13:0] HW_CLEAR_DEF = 14'h000f;

  // Vector layout: base plus slot times eight
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;
  localparam logic [3:0] SKIP_SLOT_IDX = 4'hd;

  // Timing in system clock cycles
  localparam int DETECT_CYCLES = 1;
  localparam int CALL_CYCLES = 4;
  localparam logic [1:0] CALL_CNT_LAST = 2'(CALL_CYCLES - 1);

  typedef enum {TLIC_RUN, TLIC_CALL} tlic_state_e;

  typedef struct packed {
    logic instr_done;
    logic return_from_service_done;
  } tlic_core_s;

  typedef struct packed {
    logic req;
    logic busy;
    logic hi;
    logic [15:0] vector;
  } tlic_call_s;

endpackage

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  logic ret_req = 1'b0;
  logic [13:0] src_event = '0;
  logic [13:0] sw_set = '0;
  logic [13:0] sw_clr = '0;
  logic [3:0] we = '0;
  logic [7:0] wd = '0;
  tlic_pkg::tlic_core_s core;
  tlic_pkg::tlic_call_s call;
  logic [13:0] pend;
  logic [7:0] en_m, en_x, lv_m, lv_x;
  logic act_lo, act_hi;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n, ni;

  always #20 sys_clk = !sys_clk;

  tlic_core DUT (.sys_clk(sys_clk), .rst_n(rst_n), .src_event(src_event),
    .sw_set_pend(sw_set), .sw_clr_pend(sw_clr), .main_en_we(we[0]), .main_en_wdata(wd),
    .ext_en_we(we[1]), .ext_en_wdata(wd), .main_lvl_we(we[2]), .main_lvl_wdata(wd),
    .ext_lvl_we(we[3]), .ext_lvl_wdata(wd), .core(core), .call(call), .pend_flags(pend),
    .main_irq_enable_reg(en_m), .extended_irq_enable_reg(en_x), .main_irq_level_reg(lv_m),
    .extended_irq_level_reg(lv_x), .active_lo(act_lo), .active_hi(act_hi));

  tlic_cpu_model cpu (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .ret_req(ret_req),
    .call(call), .core(core));

  task automatic results();
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  // One idle edge after each write keeps back-to-back writes apart
  task automatic wr(input int r, input logic [7:0] d);
    we[r] = 1'b1;
    wd = d;
    tick(1);
    we = '0;
    tick(1);
  endtask

  task automatic setp(input logic [13:0] m);
    sw_set = m;
    tick(1);
    sw_set = '0;
  endtask

  task automatic clrp(input logic [13:0] m);
    sw_clr = m;
    tick(1);
    sw_clr = '0;
  endtask

  task automatic ret();
    ret_req = 1'b1;
    tick(1);
    ret_req = 1'b0;
  endtask

  // Bounded wait for a forced call; also counts plain instructions seen on the way
  task automatic wcall();
    n = 0;
    ni = 0;
    while (call.req !== 1'b1 && n < 30) begin
      if (core.instr_done === 1'b1 && core.return_from_service_done !== 1'b1) ni++;
      tick(1);
      n++;
    end
  endtask

  task automatic t_reset();
    chk("enables", 16'h0000, {en_m, en_x});
    chk("levels", 16'h0000, {lv_m, lv_x});
    chk("active", 16'h0000, {14'h0, act_lo, act_hi});
    sw_set = 14'h0010;
    sw_clr = 14'h0010;
    tick(1);
    sw_set = '0;
    chk("set over clear", 16'h0010, {2'h0, pend});
    tick(1);
    sw_clr = '0;
    chk("sw clear", 16'h0000, {2'h0, pend});
  endtask

  task automatic t_gate();
    wr(0, 8'h80);
    setp(14'h0020);
    wcall();
    chk("disabled call", 16'h001e, 16'(n));
    chk("pend kept", 16'h0020, {2'h0, pend});
    wr(0, 8'h20);
    wcall();
    chk("gated call", 16'h001e, 16'(n));
    wr(0, 8'ha0);
    wcall();
    chk("sw vector", 16'h002b, call.vector);
    chk("lo active", 16'h0001, {15'h0, act_lo});
    tick(6);
    chk("flag sticky", 16'h0020, {2'h0, pend});
    slow = 1'b1;
    ret();
    wcall();
    chk("reentry gap", 16'h0001, 16'(ni));
    clrp(14'h0020);
    tick(6);
    ret();
    tick(4);
    chk("lo done", 16'h0000, {15'h0, act_lo});
    slow = 1'b0;
    wr(0, 8'h00);
  endtask

  task automatic t_fast();
    int k;
    wr(0, 8'h82);
    src_event = 14'h0002;
    tick(1);
    src_event = '0;
    chk("event flag", 16'h0002, {2'h0, pend});
    wcall();
    chk("latency", 16'h0002, 16'(n));
    chk("vector", 16'h000b, call.vector);
    k = 0;
    repeat (6) begin
      if (call.busy === 1'b1) k++;
      tick(1);
    end
    chk("busy", 16'h0004, 16'(k));
    chk("autoclear", 16'h0000, {2'h0, pend});
    ret();
    tick(3);
    wr(0, 8'h00);
  endtask

  task automatic t_prio();
    wr(0, 8'h81);
    wr(1, 8'h04);
    wr(3, 8'h04);
    setp(14'h0201);
    wcall();
    chk("hi first", 16'h004b, call.vector);
    chk("hi flag", 16'h0001, {15'h0, call.hi});
    tick(1);
    wcall();
    chk("hi kept", 16'h001e, 16'(n));
    clrp(14'h0200);
    ret();
    wcall();
    chk("lo after", 16'h0003, call.vector);
    chk("levels", 16'h0002, {14'h0, act_lo, act_hi});
    tick(6);
    setp(14'h0200);
    wcall();
    chk("preempt", 16'h0003, {14'h0, act_lo, act_hi});
    clrp(14'h0200);
    tick(5);
    ret();
    tick(3);
    ret();
    tick(3);
    chk("idle", 16'h0000, {14'h0, act_lo, act_hi});
  endtask

  task automatic t_tie();
    wr(0, 8'h8c);
    wr(1, 8'hc0);
    wr(2, 8'hff);
    chk("ext en", 16'h0080, {8'h0, en_x});
    chk("main lvl", 16'h007f, {8'h0, lv_m});
    wr(2, 8'h00);
    wr(3, 8'h00);
    setp(14'h200c);
    wcall();
    chk("tie a", 16'h0013, call.vector);
    tick(5);
    ret();
    wcall();
    chk("tie b", 16'h001b, call.vector);
    tick(5);
    ret();
    wcall();
    chk("src13", 16'h0073, call.vector);
    clrp(14'h2000);
    tick(4);
    ret();
  endtask

  // Cuts a hang short well past the longest expected run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    tick(6);
    rst_n = 1'b1;
    tick(1);
    t_reset();
    t_gate();
    t_fast();
    t_prio();
    t_tie();
    tick(4);
    results();
  end
endmodule

`default_nettype wire

/* testbench/tlic_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module tlic_cpu_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bench control
  input wire logic slow,
  input wire logic ret_req,
  // Controller side
  input wire tlic_pkg::tlic_call_s call,
  output var tlic_pkg::tlic_core_s core
);
  logic gap_reg;
  logic ret_reg;
  logic fire;

  // No instruction completes while the forced call runs
  assign fire = !call.busy && (!slow || gap_reg);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gap_reg <= 1'b0;
      ret_reg <= 1'b0;
      core <= '0;
    end else begin
      gap_reg <= !gap_reg;
      // A return asked for during a call waits for the next instruction
      ret_reg <= (ret_reg || ret_req) && !fire;
      core.instr_done <= fire;
      core.return_from_service_done <= fire && (ret_reg || ret_req);
    end
  end
endmodule

`default_nettype wire
